// ### src/sfwp_pkg.sv
// Constants, types and functional notes of the flash write-protect block
// Functional notes
// - Fine-select clear: 64KB blocks; 00 none, 01 one, 10 two, 11 all
// - Fine-select set: 4KB to 32KB or all, from the three size bits
// - Complement bit set protects exactly the rest of the selected region
// - Protected addresses stay readable but their contents never change
// - Data-changing commands need the write enable latch set beforehand
// - Protect pin low freezes block-protect and status-protect bits
// - In deep power-down only the release command is honoured
// - A command must be whole bytes, ending on a byte boundary
// - Contents change only after a complete, well-formed command
// - Command decoder starts in standby after power-up
// - Erased bytes read FFh and status starts at 00h
// - Suspend takes a latency before the suspended state is reported
// - Program or erase touching any protected byte is dropped whole
// - Unknown opcode sends the decoder to standby until next select
package sfwp_pkg;
    // ==================================================================
    // Array geometry and protection sizes
    localparam int RANGE_W = 19;
    localparam logic [18:0] SZ_4K = 19'h01000;
    localparam logic [18:0] SZ_8K = 19'h02000;
    localparam logic [18:0] SZ_16K = 19'h04000;
    localparam logic [18:0] SZ_32K = 19'h08000;
    localparam logic [18:0] SZ_64K = 19'h10000;
    localparam logic [18:0] SZ_128K = 19'h20000;
    localparam logic [18:0] SZ_ALL = 19'h40000;
    localparam logic [18:0] SECT_MASK = 19'h7F000;
    localparam logic [18:0] ONE_BYTE = 19'h00001;
    // ==================================================================
    // Opcodes
    localparam logic [7:0] OPC_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] OPC_WRDI = 8'h04;
    localparam logic [7:0] OPC_WRSR = 8'h01;
    localparam logic [7:0] OPC_PP = 8'h02;
    localparam logic [7:0] OPC_SE = 8'h20;
    localparam logic [7:0] OPC_CE = 8'h60;
    localparam logic [7:0] OPC_DPD = 8'hB9;
    localparam logic [7:0] OPC_RDP = 8'hAB;
    localparam logic [7:0] OPC_PES = 8'h75;
    localparam logic [7:0] OPC_PER = 8'h7A;
    // ==================================================================
    // Status and config fields, reset values
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP0 = 2;
    localparam int ST_SRP0 = 7;
    localparam int CF_SRP1 = 0;
    localparam int CF_CMP = 6;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [1:0] OP_PROG = 2'h0;
    localparam logic [1:0] OP_SECT = 2'h1;
    localparam logic [1:0] OP_CHIP = 2'h2;
    // ==================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SUSP_LAT_NS = 30000;
    localparam int SUSP_LAT_CYC = SUSP_LAT_NS / CLK_PERIOD_NS;
    localparam int PRS_GAP_US = 100;
    localparam int ERS_GAP_US = 200;
    localparam int VSL_US = 70;
    typedef enum logic [1:0] {
        ST_STANDBY, ST_OPCODE, ST_ARGS, ST_IGNORE
    } sfwp_state_t;
endpackage : sfwp_pkg

// ### src/sfwp_link_if.sv
// Byte carrier from the serial-clock receiver to the system-clock core
`timescale 1ns/1ps
interface sfwp_link_if;
    logic [7:0] byte_data;
    logic byte_tgl;
    logic partial;
    modport rx (output byte_data, output byte_tgl, output partial);
    modport core (input byte_data, input byte_tgl, input partial);
endinterface : sfwp_link_if

// ### src/sfwp_prot_decode.sv
// Decode of protect bits into a protected byte range [lo, hi)
`timescale 1ns/1ps
module sfwp_prot_decode import sfwp_pkg::*; (
    input logic [4:0] bp,
    input logic cmp,
    output logic [18:0] prot_lo,
    output logic [18:0] prot_hi
);
    logic [18:0] sz;
    logic top;

    // Size select, then place region and optionally take its complement
    always_comb begin
        sz = 19'h00000;
        top = !bp[3];
        if (!bp[4]) begin
            case (bp[1:0])
                2'h1: sz = SZ_64K;
                2'h2: sz = SZ_128K;
                2'h3: sz = SZ_ALL;
                default: sz = 19'h00000;
            endcase
        end else begin
            case (bp[2:0])
                3'h1: sz = SZ_4K;
                3'h2: sz = SZ_8K;
                3'h3: sz = SZ_16K;
                3'h4, 3'h5, 3'h6: sz = SZ_32K;
                3'h7: sz = SZ_ALL;
                default: sz = 19'h00000;
            endcase
        end
        // Complement keeps one boundary; none and all swap for free
        if (!cmp) begin
            prot_lo = top ? SZ_ALL - sz : 19'h00000;
            prot_hi = top ? SZ_ALL : sz;
        end else begin
            prot_lo = top ? 19'h00000 : sz;
            prot_hi = top ? SZ_ALL - sz : SZ_ALL;
        end
    end
endmodule : sfwp_prot_decode

// ### src/sfwp_link_rx.sv
// Serial-clock side: bit shifter and byte handoff to the core
`timescale 1ns/1ps
module sfwp_link_rx import sfwp_pkg::*; (
    input logic sclk,
    input logic resetn,
    input logic cs_n,
    input logic mosi,
    sfwp_link_if.rx lk
);
    logic first_reg;
    logic [6:0] shift_reg, shift_next;
    logic [2:0] cnt_reg, cnt_next, cnt_cur;
    logic [7:0] byte_reg, byte_next;
    logic tgl_reg, tgl_next;
    logic part_reg, part_next;

    // Armed while deselected; the clock may be stopped then
    always_ff @(posedge sclk or negedge resetn or posedge cs_n) begin
        if (!resetn) begin
            first_reg <= 1'b1;
        end else if (cs_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // Count restarts on the first edge, so the last count survives
    always_comb begin
        cnt_cur = first_reg ? 3'h0 : cnt_reg;
        shift_next = {shift_reg[5:0], mosi};
        cnt_next = cnt_cur + 3'h1;
        byte_next = byte_reg;
        tgl_next = tgl_reg;
        if (cnt_cur == 3'h7) begin
            byte_next = {shift_reg, mosi};
            tgl_next = !tgl_reg;
        end
        part_next = (cnt_next != 3'h0);
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= 7'h00;
            cnt_reg <= 3'h0;
            byte_reg <= 8'h00;
            tgl_reg <= 1'b0;
            part_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            byte_reg <= byte_next;
            tgl_reg <= tgl_next;
            part_reg <= part_next;
        end
    end

    assign lk.byte_data = byte_reg;
    assign lk.byte_tgl = tgl_reg;
    assign lk.partial = part_reg;

    a_byte_handoff: assert property (
        @(posedge sclk) disable iff (!resetn)
        (cnt_cur == 3'h7) |=> (tgl_reg != $past(tgl_reg)) && !part_reg)
        else $error("byte boundary not handed over");
endmodule : sfwp_link_rx

// ### src/sfwp_core.sv
// Top: command decode and write protection of the serial flash
`timescale 1ns/1ps
module sfwp_core import sfwp_pkg::*; #(
    parameter int SUSP_CYC = SUSP_LAT_CYC
) (
    input logic clk_sys,
    input logic resetn,
    input logic sclk,
    input logic cs_n,
    input logic mosi,
    input logic wp_n,
    input logic arr_busy,
    output logic [7:0] status_o,
    output logic [7:0] config_o,
    output logic arr_req_o,
    output logic [1:0] arr_op_o,
    output logic [17:0] arr_addr_o,
    output logic [7:0] arr_data_o,
    output logic arr_suspend_o,
    output logic suspended_o,
    output logic deep_pd_o,
    output logic standby_o,
    output logic reject_o
);
    // ==================================================================
    // Parameter check
    if (SUSP_CYC < 1 || SUSP_CYC > 65535) begin : g_chk
        $error("SUSP_CYC out of range");
    end

    // ==================================================================
    // Functions
    function automatic logic sfwp_known(input logic [7:0] op);
        case (op)
            OPC_WRITE_ENABLE_COMMAND, OPC_WRDI, OPC_WRSR, OPC_PP, OPC_SE,
            OPC_CE, OPC_DPD, OPC_RDP, OPC_PES, OPC_PER: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : sfwp_known

    // Byte count including the opcode
    function automatic logic sfwp_len_ok(input logic [7:0] op,
                                         input logic [2:0] n);
        case (op)
            OPC_WRSR: return (n == 3'h2) || (n == 3'h3);
            OPC_SE: return n == 3'h4;
            OPC_PP: return n == 3'h5;
            default: return n == 3'h1;
        endcase
    endfunction : sfwp_len_ok

    function automatic logic sfwp_hit(input logic [18:0] a,
                                      input logic [18:0] len,
                                      input logic [18:0] lo,
                                      input logic [18:0] hi);
        logic [18:0] e;
        e = 19'(a + len);
        return (lo < hi) && (a < hi) && (e > lo);
    endfunction : sfwp_hit

    // ==================================================================
    // Link receiver and crossing
    sfwp_link_if lk ();

    sfwp_link_rx u_rx (
        .sclk(sclk),
        .resetn(resetn),
        .cs_n(cs_n),
        .mosi(mosi),
        .lk(lk)
    );

    logic wp_s1, wp_s2, cs_s1, cs_s2, cs_s3, cs_s4;
    logic tg_s1, tg_s2, tg_s3, pt_s1, pt_s2;

    // Two flops per pin or foreign level; extra stages only for edges
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            cs_s4 <= 1'b1;
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_s3 <= 1'b0;
            pt_s1 <= 1'b0;
            pt_s2 <= 1'b0;
        end else begin
            wp_s1 <= wp_n;
            wp_s2 <= wp_s1;
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            cs_s4 <= cs_s3;
            tg_s1 <= lk.byte_tgl;
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            pt_s1 <= lk.partial;
            pt_s2 <= pt_s1;
        end
    end

    logic cs_fall, frame_end, byte_evt;
    // Frame end lags one cycle so a last byte racing it is seen first
    assign cs_fall = cs_s3 && !cs_s2;
    assign frame_end = cs_s3 && !cs_s4;
    assign byte_evt = tg_s3 != tg_s2;

    // ==================================================================
    // Control state
    sfwp_state_t st_reg, st_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [31:0] argd_reg, argd_next;
    logic wel_reg, wel_next, wip_reg;
    logic [4:0] bp_reg, bp_next;
    logic srp0_reg, srp0_next, srp1_reg, srp1_next;
    logic cmp_reg, cmp_next, dpd_reg, dpd_next;
    logic [15:0] scnt_reg, scnt_next;
    logic sreq_reg, sreq_next, susp_reg, susp_next;
    logic req_reg, req_next, rej_reg, rej_next;
    logic [1:0] op_reg, op_next;
    logic [17:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic stby_reg, stby_next;

    // Target range of the pending command, live protection decode
    logic [18:0] prot_lo, prot_hi, tgt_a, tgt_len;
    logic [23:0] addr24;
    logic [7:0] sbyte, cbyte;
    logic is_change, tgt_hit, well, exec_ok, busy;

    sfwp_prot_decode u_dec (
        .bp(bp_reg),
        .cmp(cmp_reg),
        .prot_lo(prot_lo),
        .prot_hi(prot_hi)
    );

    assign addr24 = (cmd_reg == OPC_PP) ? argd_reg[31:8]
                                        : argd_reg[23:0];
    assign is_change = (cmd_reg == OPC_PP) || (cmd_reg == OPC_SE) ||
                       (cmd_reg == OPC_CE);
    // Upper address bits beyond the array are ignored
    assign tgt_a = (cmd_reg == OPC_CE) ? 19'h00000 :
                   (cmd_reg == OPC_SE) ?
                   ({1'b0, addr24[17:0]} & SECT_MASK) :
                   {1'b0, addr24[17:0]};
    assign tgt_len = (cmd_reg == OPC_CE) ? SZ_ALL :
                     (cmd_reg == OPC_SE) ? SZ_4K : ONE_BYTE;
    assign tgt_hit = sfwp_hit(tgt_a, tgt_len, prot_lo, prot_hi);
    assign well = !pt_s2 && sfwp_len_ok(cmd_reg, cnt_reg);
    assign exec_ok = frame_end && (st_reg == ST_ARGS) && well;
    assign busy = wip_reg || req_reg || (scnt_reg != 16'h0000) ||
                  susp_reg;
    // Two-byte write carries status only; three adds the config byte
    assign sbyte = (cnt_reg == 3'h3) ? argd_reg[15:8] : argd_reg[7:0];
    assign cbyte = argd_reg[7:0];

    // Byte decode, end-of-frame execution and suspend timing
    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        cnt_next = cnt_reg;
        argd_next = argd_reg;
        wel_next = wel_reg;
        bp_next = bp_reg;
        srp0_next = srp0_reg;
        srp1_next = srp1_reg;
        cmp_next = cmp_reg;
        dpd_next = dpd_reg;
        scnt_next = scnt_reg;
        sreq_next = sreq_reg;
        susp_next = susp_reg;
        req_next = 1'b0;
        rej_next = 1'b0;
        op_next = op_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        if (cs_fall) begin
            st_next = ST_OPCODE;
            cnt_next = 3'h0;
        end else if (byte_evt) begin
            case (st_reg)
                ST_OPCODE: begin
                    cmd_next = lk.byte_data;
                    cnt_next = 3'h1;
                    if (!sfwp_known(lk.byte_data)) begin
                        st_next = ST_IGNORE;
                    end else if (dpd_reg &&
                                 lk.byte_data != OPC_RDP) begin
                        st_next = ST_IGNORE;
                    end else begin
                        st_next = ST_ARGS;
                    end
                end
                ST_ARGS: begin
                    argd_next = {argd_reg[23:0], lk.byte_data};
                    if (cnt_reg != 3'h7) begin
                        cnt_next = cnt_reg + 3'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (frame_end) begin
            st_next = ST_STANDBY;
            // A frame cut inside its first byte is malformed as well
            if ((st_reg == ST_ARGS && !well) ||
                (st_reg == ST_OPCODE && pt_s2)) begin
                rej_next = 1'b1;
            end
        end
        if (exec_ok) begin
            case (cmd_reg)
                OPC_WRITE_ENABLE_COMMAND: wel_next = 1'b1;
                OPC_WRDI: wel_next = 1'b0;
                OPC_WRSR: begin
                    if (wel_reg && !busy) begin
                        wel_next = 1'b0;
                        if (wp_s2) begin
                            bp_next = sbyte[ST_BP0 +: 5];
                            srp0_next = sbyte[ST_SRP0];
                            if (cnt_reg == 3'h3) begin
                                srp1_next = cbyte[CF_SRP1];
                            end
                        end
                        if (cnt_reg == 3'h3) begin
                            cmp_next = cbyte[CF_CMP];
                        end
                    end else begin
                        rej_next = 1'b1;
                    end
                end
                OPC_PP, OPC_SE, OPC_CE: begin
                    if (wel_reg && !busy && !tgt_hit) begin
                        wel_next = 1'b0;
                        req_next = 1'b1;
                        addr_next = tgt_a[17:0];
                        op_next = (cmd_reg == OPC_PP) ? OP_PROG :
                                  (cmd_reg == OPC_SE) ? OP_SECT : OP_CHIP;
                        data_next = (cmd_reg == OPC_PP) ?
                                    argd_reg[7:0] : ERASED_BYTE;
                    end else begin
                        rej_next = 1'b1;
                    end
                end
                OPC_DPD: begin
                    if (!busy) begin
                        dpd_next = 1'b1;
                    end else begin
                        rej_next = 1'b1;
                    end
                end
                OPC_RDP: dpd_next = 1'b0;
                OPC_PES: begin
                    if (wip_reg && !sreq_reg) begin
                        sreq_next = 1'b1;
                        scnt_next = 16'(SUSP_CYC);
                    end else begin
                        rej_next = 1'b1;
                    end
                end
                OPC_PER: begin
                    if (susp_reg) begin
                        susp_next = 1'b0;
                        sreq_next = 1'b0;
                    end else begin
                        rej_next = 1'b1;
                    end
                end
                default: rej_next = 1'b1;
            endcase
        end
        // Suspended is reported only once the latency has run out
        if (scnt_reg != 16'h0000) begin
            scnt_next = scnt_reg - 16'h0001;
            if (scnt_reg == 16'h0001) begin
                susp_next = 1'b1;
            end
        end
        stby_next = (st_next == ST_STANDBY) || (st_next == ST_IGNORE);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_STANDBY;
            cmd_reg <= 8'h00;
            cnt_reg <= 3'h0;
            argd_reg <= 32'h00000000;
            wel_reg <= STATUS_RST[ST_WEL];
            wip_reg <= STATUS_RST[ST_WIP];
            bp_reg <= STATUS_RST[ST_BP0 +: 5];
            srp0_reg <= STATUS_RST[ST_SRP0];
            srp1_reg <= CONFIG_RST[CF_SRP1];
            cmp_reg <= CONFIG_RST[CF_CMP];
            dpd_reg <= 1'b0;
            scnt_reg <= 16'h0000;
            sreq_reg <= 1'b0;
            susp_reg <= 1'b0;
            req_reg <= 1'b0;
            rej_reg <= 1'b0;
            op_reg <= OP_PROG;
            addr_reg <= 18'h00000;
            data_reg <= ERASED_BYTE;
            stby_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            cnt_reg <= cnt_next;
            argd_reg <= argd_next;
            wel_reg <= wel_next;
            wip_reg <= arr_busy;
            bp_reg <= bp_next;
            srp0_reg <= srp0_next;
            srp1_reg <= srp1_next;
            cmp_reg <= cmp_next;
            dpd_reg <= dpd_next;
            scnt_reg <= scnt_next;
            sreq_reg <= sreq_next;
            susp_reg <= susp_next;
            req_reg <= req_next;
            rej_reg <= rej_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            stby_reg <= stby_next;
        end
    end

    // ==================================================================
    // Outputs, status word assembled from its field positions
    always_comb begin
        status_o = 8'h00;
        status_o[ST_WIP] = wip_reg;
        status_o[ST_WEL] = wel_reg;
        status_o[ST_BP0 +: 5] = bp_reg;
        status_o[ST_SRP0] = srp0_reg;
        config_o = 8'h00;
        config_o[CF_SRP1] = srp1_reg;
        config_o[CF_CMP] = cmp_reg;
    end

    assign arr_req_o = req_reg;
    assign arr_op_o = op_reg;
    assign arr_addr_o = addr_reg;
    assign arr_data_o = data_reg;
    assign arr_suspend_o = sreq_reg;
    assign suspended_o = susp_reg;
    assign deep_pd_o = dpd_reg;
    assign standby_o = stby_reg;
    assign reject_o = rej_reg;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_change_end;
        exec_ok && is_change;
    endsequence

    sequence s_opcode_in;
        byte_evt && !cs_fall && (st_reg == ST_OPCODE);
    endsequence

    a_prot_block: assert property (
        s_change_end ##0 tgt_hit |=> !arr_req_o ##1 !arr_req_o)
        else $error("protected range was changed");
    a_wel_gate: assert property (
        $rose(arr_req_o) |-> $past(wel_reg) && !wel_reg)
        else $error("change issued without write enable");
    a_commit_end: assert property (
        arr_req_o |-> $past(frame_end) && $past(well))
        else $error("change issued before frame end");
    a_len_check: assert property (
        frame_end && ((st_reg == ST_ARGS && !well) ||
        (st_reg == ST_OPCODE && pt_s2))
        |=> !arr_req_o && reject_o && $stable(bp_reg))
        else $error("malformed command executed");
    a_wp_lock: assert property (
        !wp_s2 |=> $stable(bp_reg) && $stable(srp0_reg) &&
        $stable(srp1_reg))
        else $error("protect bits changed under pin lock");
    a_dpd_ignore: assert property (
        s_opcode_in ##0 (dpd_reg && lk.byte_data != OPC_RDP)
        |=> (st_reg == ST_IGNORE) ##1 deep_pd_o)
        else $error("command honoured in deep power-down");
    a_unknown_stby: assert property (
        s_opcode_in ##0 !sfwp_known(lk.byte_data)
        |=> (st_reg == ST_IGNORE) ##1 standby_o)
        else $error("unknown opcode not sent to standby");
    a_susp_latency: assert property (
        $rose(suspended_o) |-> $past(scnt_reg) == 16'h0001 &&
        arr_suspend_o)
        else $error("suspend reported without latency");
    a_erase_fill: assert property (
        arr_req_o && (arr_op_o != OP_PROG)
        |-> arr_data_o == ERASED_BYTE)
        else $error("erase fill value wrong");
endmodule : sfwp_core

// ### bench/sfwp_host.sv
// Host-side serial controller model for write-only frames
`timescale 1ns/1ps
module sfwp_host (
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    // =========
    // Idle: select high, clock still
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end
    // Mode 0 frame, MSB first; long gap so the core sees the end
    task automatic send(input logic [39:0] d, input int nb);
        #3.3 cs_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            mosi = d[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        mosi = ~mosi; // Released line never shows a stale bit
        #200;
    endtask : send
endmodule : sfwp_host

// ### bench/sfwp_core_tb.sv
// Self-checking bench of the flash write-protect core
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
$display("Error %s exp %h got %h", n, e, g); end end
module sfwp_core_tb import sfwp_pkg::*;;
    localparam logic [28:0] REJ = 29'h10000000;
    logic clk_sys = 1'b0, resetn = 1'b0, wp_n = 1'b1, arr_busy = 1'b0;
    wire sclk, cs_n, mosi, arr_req_o, arr_suspend_o, suspended_o;
    wire deep_pd_o, standby_o, reject_o;
    wire [7:0] status_o, config_o, arr_data_o;
    wire [1:0] arr_op_o;
    wire [17:0] arr_addr_o;
    int n_fail = 0, n_checks = 0, k;
    logic [28:0] expq[$];
    logic [28:0] got, e;
    logic [17:0] a;
    logic [7:0] dt;
    logic [4:0] bp;
    logic c, r;
    // Protect bits, complement, sector, refused
    logic [24:0] tbl[7] = '{{5'h01, 1'b0, 18'h30000, 1'b1},
        {5'h01, 1'b0, 18'h2F000, 1'b0},
        {5'h11, 1'b0, 18'h3F000, 1'b1},
        {5'h11, 1'b0, 18'h3E000, 1'b0},
        {5'h19, 1'b0, 18'h00000, 1'b1},
        {5'h11, 1'b1, 18'h3F000, 1'b0},
        {5'h11, 1'b1, 18'h3E000, 1'b1}};
    // =========
    // Clock, partner and design
    always #2.5 clk_sys = ~clk_sys;
    sfwp_host u_host (.sclk, .cs_n, .mosi);
    sfwp_core #(.SUSP_CYC(60)) u_dut (.clk_sys, .resetn, .sclk, .cs_n,
        .mosi, .wp_n, .arr_busy, .status_o, .config_o, .arr_req_o,
        .arr_op_o, .arr_addr_o, .arr_data_o, .arr_suspend_o,
        .suspended_o, .deep_pd_o, .standby_o, .reject_o);
    // Every pulse must match the oldest note
    always @(negedge clk_sys) if (arr_req_o === 1'b1 || reject_o === 1'b1) begin
        got = reject_o ? REJ : {1'b0, arr_op_o, arr_addr_o, arr_data_o};
        e = expq.size() ? expq.pop_front() : 29'h1FFFFFFF;
        `CHK("array_op", e, got)
    end
    // =========
    // Frame helpers; note first, then send
    task automatic fr(input logic [39:0] d, input int nb,
        input logic [28:0] x, input bit q);
        if (q) expq.push_back(x);
        u_host.send(d, nb);
    endtask : fr
    task automatic we();
        fr(40'h06, 8, 29'h0, 1'b0);
    endtask : we
    task automatic results();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // Hang guard
    initial begin
        #500000;
        n_fail++;
        $display("Error watchdog exp done got hang");
        results();
    end
    // =========
    // Main sequence
    initial begin
        void'($urandom(32'hFB6DD71A));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) resetn = 1'b1;
        `CHK("status", 8'h00, status_o)
        `CHK("standby", 1'b1, standby_o)
        repeat (4) @(negedge clk_sys);
        $display("test reset done");
        dt = 8'($urandom);
        a = 18'($urandom);
        fr({8'h02, 6'h00, a, dt}, 40, REJ, 1'b1);
        we();
        `CHK("wel", 1'b1, status_o[1])
        fr({8'h02, 6'h00, a, dt}, 40, {1'b0, OP_PROG, a, dt}, 1'b1);
        `CHK("wel", 1'b0, status_o[1])
        we();
        fr(40'h02, 7, REJ, 1'b1);
        $display("test write_enable done");
        foreach (tbl[i]) begin
            {bp, c, a, r} = tbl[i];
            we();
            fr({8'h01, 1'b0, bp, 2'b00, 1'b0, c, 6'h00}, 24, 29'h0, 1'b0);
            `CHK("config", {1'b0, c, 6'h00}, config_o)
            we();
            fr({8'h20, 6'h00, a}, 32, r ? REJ : {1'b0, OP_SECT, a, 8'hFF},
                1'b1);
        end
        $display("test protect done");
        @(negedge clk_sys) wp_n = 1'b0;
        we();
        fr(40'h010000, 24, 29'h0, 1'b0);
        `CHK("cmp_free", 8'h00, config_o)
        `CHK("bp_frozen", bp, status_o[6:2])
        @(negedge clk_sys) wp_n = 1'b1;
        // Chip erase overlaps the top sector, protected again once the complement cleared
        we();
        fr(40'h60, 8, REJ, 1'b1);
        `CHK("wel_kept", 1'b1, status_o[1])
        fr(40'h04, 8, 29'h0, 1'b0);
        `CHK("wel_off", 1'b0, status_o[1])
        fr(40'hB9, 8, 29'h0, 1'b0);
        `CHK("deep_pd", 1'b1, deep_pd_o)
        we();
        `CHK("wel_dpd", 1'b0, status_o[1])
        fr(40'hAB, 8, 29'h0, 1'b0);
        `CHK("deep_pd", 1'b0, deep_pd_o)
        fr(40'h9F00, 16, 29'h0, 1'b0);
        `CHK("standby", 1'b1, standby_o)
        $display("test power_down done");
        @(negedge clk_sys) arr_busy = 1'b1;
        // Single suspend per resume keeps the resume-to-suspend gap
        fr(40'h75, 8, 29'h0, 1'b0);
        `CHK("suspend", 1'b1, arr_suspend_o)
        `CHK("suspended", 1'b0, suspended_o)
        for (k = 0; k < 40 && suspended_o !== 1'b1; k++) @(negedge clk_sys);
        `CHK("suspended", 1'b1, suspended_o)
        fr(40'h7A, 8, 29'h0, 1'b0);
        `CHK("resumed", 1'b0, suspended_o)
        @(negedge clk_sys) arr_busy = 1'b0;
        $display("test suspend done");
        `CHK("pending", 0, expq.size())
        results();
    end
endmodule : sfwp_core_tb
